// ---- verilog/sarc_core.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sarc_map.svh"
// Overview of operation
// RL1: both controls low 40 ns starts conversion
// RL2: busy low until result register updated
// RL3: commands ignored while busy low
// RL4: host raises a control before busy rises; t_restart holds both low past busy rise
// RL5: controls still low at busy rise restart
// RL6: tracking resumes when conversion ends
// RL7: host spaces commands by 10 us; t_single issues a second start mid-conversion
// RL8: controls are level-sensitive or, either order
// RL9: host sets other line 10 ns early
// RL10: bus driven only read high, select low
// RL11: select tied low works via read edges
// RL12: read fall or select fall floats bus
// RL13: unsigned straight binary, word or bytes
// RL14: codes 000 to fff, 800 midscale
// RL15: byte select may change during cycle
// RL16: data valid when busy rises
// RL17: old result readable while busy low
// RL18: host avoids reads late in conversion
// RL19: host avoids reads during conversion; t_single reads while busy low
// RL20: new data valid within 8 us
// RL21: msb first, padding low, byte swap
// RL22: result register held until next conversion
module sarc_core (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   select_n,
   input  wire logic                   read_conv,
   input  wire logic                   byte_sel,
   input  wire logic [`SARC_RES_W-1:0] sample_code,
   output logic                        busy_n,
   output logic                        hold,
   output logic      [`SARC_BUS_W-1:0] result_lines_out,
   output logic      [`SARC_BUS_W-1:0] result_lines_oe_n,
   output logic      [`SARC_RES_W-1:0] log_data,
   output logic                        log_valid,
   input  wire logic                   log_ready,
   output logic                        sample_dropped
);
   // ****************************************
   // declarations
   // ****************************************
   localparam int START_CYC = `SARC_START_CYC;
   localparam int CONV_CYC  = `SARC_CONV_CYC;
   localparam int OLD_CYC   = `SARC_OLD_VALID_CYC;
   sarc_pkg::sarc_state_e  state_reg;
   sarc_pkg::sarc_state_e  state_next;
   logic [2:0]             low_cnt_reg;
   logic [13:0]            conv_cnt_reg;
   logic [10:0]            age_cnt_reg;
   logic [`SARC_RES_W-1:0] result_reg;
   logic [`SARC_RES_W-1:0] sar_code_reg;
   logic                   both_low;
   logic                   start_ok;
   logic                   conv_done;
   logic [`SARC_BUS_W-1:0] lanes;
   logic                   fifo_in_ready;
   logic                   read_en;
   // conversion decode shared by several checks
   function automatic logic in_conv(input sarc_pkg::sarc_state_e s);
      return (s == sarc_pkg::SARC_CONVERT);
   endfunction
   // ****************************************
   // command detection
   // ****************************************
   // wired-or of the two active-low controls
   assign both_low  = !select_n && !read_conv; // see RL8 see RL11
   assign start_ok  = both_low && (low_cnt_reg >= 3'(START_CYC - 1)); // see RL1
   assign conv_done = (state_reg == sarc_pkg::SARC_CONVERT) && (conv_cnt_reg == 14'(CONV_CYC - 1));
   assign read_en   = !select_n && read_conv; // see RL10 see RL12
   // low-time filter; except in SARC_REARM, glitches shorter than the minimum never start
   always_ff @(posedge clk) begin
      if (rst) begin
         low_cnt_reg <= 3'h0;
      end else if (!both_low) begin
         low_cnt_reg <= 3'h0;
      end else if (low_cnt_reg != 3'h7) begin
         low_cnt_reg <= low_cnt_reg + 3'h1;
      end
   end
   // ****************************************
   // conversion sequencer
   // ****************************************
   // state decision
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         sarc_pkg::SARC_TRACK: begin
            if (start_ok) begin
               state_next = sarc_pkg::SARC_CONVERT; // see RL1
            end
         end
         sarc_pkg::SARC_CONVERT: begin
            // commands during conversion are simply not looked at
            if (conv_done) begin
               state_next = sarc_pkg::SARC_REARM; // see RL3
            end
         end
         sarc_pkg::SARC_REARM: begin
            // controls still low when busy rises: restart with no acquisition
            if (both_low) begin
               state_next = sarc_pkg::SARC_CONVERT; // see RL5 see RL4
            end else begin
               state_next = sarc_pkg::SARC_TRACK; // see RL6
            end
         end
         default: begin
            state_next = sarc_pkg::SARC_TRACK;
         end
      endcase
   end
   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= sarc_pkg::SARC_TRACK;
      end else begin
         state_reg <= state_next;
      end
   end
   // conversion timer, 8 us end to end
   always_ff @(posedge clk) begin
      if (rst) begin
         conv_cnt_reg <= 14'h0000;
      end else if (state_reg == sarc_pkg::SARC_CONVERT && !conv_done) begin
         conv_cnt_reg <= conv_cnt_reg + 14'h0001; // see RL20
      end else begin
         conv_cnt_reg <= 14'h0000;
      end
   end
   // sample taken when hold begins
   always_ff @(posedge clk) begin
      if (rst) begin
         sar_code_reg <= `SARC_RESULT_RESET;
      end else if (state_reg != sarc_pkg::SARC_CONVERT && state_next == sarc_pkg::SARC_CONVERT) begin
         sar_code_reg <= sample_code; // see RL13 see RL14
      end
   end
   // output register only moves at end of conversion
   always_ff @(posedge clk) begin
      if (rst) begin
         result_reg <= `SARC_RESULT_RESET;
      end else if (conv_done) begin
         result_reg <= sar_code_reg; // see RL22 see RL2
      end
   end
   // busy and hold follow the sequencer; busy rises on the same edge as the result update
   always_ff @(posedge clk) begin
      if (rst) begin
         busy_n <= 1'b1;
         hold   <= 1'b0;
      end else begin
         busy_n <= (state_next != sarc_pkg::SARC_CONVERT); // see RL2 see RL16
         hold   <= (state_next == sarc_pkg::SARC_CONVERT); // see RL1 see RL6
      end
   end
   // age of a conversion, saturating at 11'h7ff
   always_ff @(posedge clk) begin
      if (rst) begin
         age_cnt_reg <= 11'h000;
      end else if (state_reg != sarc_pkg::SARC_CONVERT) begin
         age_cnt_reg <= 11'h000;
      end else if (age_cnt_reg != 11'h7ff) begin
         age_cnt_reg <= age_cnt_reg + 11'h001; // see RL17
      end
   end
   // ****************************************
   // result bus
   // ****************************************
   sarc_lanes u_lanes (
      .code      (result_reg),
      .byte_swap (byte_sel),
      .lanes     (lanes)
   );
   // registered drive; enable low means driving
   always_ff @(posedge clk) begin
      if (rst) begin
         result_lines_out  <= 16'h0000;
         result_lines_oe_n <= 16'hffff;
      end else begin
         result_lines_out  <= lanes; // see RL17 see RL15
         result_lines_oe_n <= read_en ? 16'h0000 : 16'hffff; // see RL10 see RL12
      end
   end
   // ****************************************
   // result log
   // ****************************************
   // each finished result is queued; a full queue drops it and says so
   sarc_fifo #(
      .WIDTH (`SARC_RES_W),
      .DEPTH (`SARC_FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_data   (sar_code_reg),
      .in_valid  (conv_done),
      .in_ready  (fifo_in_ready),
      .out_data  (log_data),
      .out_valid (log_valid),
      .out_ready (log_ready)
   );
   always_ff @(posedge clk) begin
      if (rst) begin
         sample_dropped <= 1'b0;
      end else begin
         sample_dropped <= conv_done && !fifo_in_ready;
      end
   end
   // ****************************************
   // checks
   // ****************************************
   busy_after_start_a: assert property (@(posedge clk) disable iff (rst) // see RL2
      (state_reg == sarc_pkg::SARC_TRACK && start_ok) |=> !busy_n)
      else $error("busy did not fall after start");
   busy_holds_a: assert property (@(posedge clk) disable iff (rst) // see RL3
      $fell(busy_n) |-> !busy_n [*8])
      else $error("busy rose too early");
   conv_length_a: assert property (@(posedge clk) disable iff (rst) // see RL20
      $fell(busy_n) |-> ##[1:800] $rose(busy_n))
      else $error("conversion ran past limit");
   result_stable_a: assert property (@(posedge clk) disable iff (rst) // see RL22
      (!busy_n && !conv_done) |=> $stable(result_reg))
      else $error("result changed mid conversion");
   bus_float_a: assert property (@(posedge clk) disable iff (rst) // see RL10
      !read_en |=> (result_lines_oe_n == 16'hffff))
      else $error("bus driven when not read");
   pad_zero_a: assert property (@(posedge clk) disable iff (rst) // see RL21
      !byte_sel |=> (result_lines_out[3:0] == 4'h0))
      else $error("padding lines not low");
   restart_a: assert property (@(posedge clk) disable iff (rst) // see RL5
      (state_reg == sarc_pkg::SARC_REARM && both_low) |=> !busy_n)
      else $error("no restart with controls low");
   short_pulse_a: assert property (@(posedge clk) disable iff (rst) // see RL1
      (busy_n && !both_low) |=> busy_n)
      else $error("start without both controls low");
   data_at_rise_a: assert property (@(posedge clk) disable iff (rst) // see RL16
      $rose(busy_n) |-> (result_reg == $past(sar_code_reg)))
      else $error("result not ready at busy rise");
   // ****************************************
   // checks: sequencer
   // ****************************************
   // busy, hold and state must agree cycle by cycle
   conv_busy_a: assert property (@(posedge clk) disable iff (rst) // see RL2
      in_conv(state_reg) |-> !busy_n)
      else $error("busy high during conversion");
   track_idle_a: assert property (@(posedge clk) disable iff (rst) // see RL6
      (state_reg == sarc_pkg::SARC_TRACK) |-> !hold)
      else $error("hold while tracking");
   busy_stays_a: assert property (@(posedge clk) disable iff (rst) // see RL3
      (in_conv(state_reg) && !conv_done) |=> !busy_n)
      else $error("busy rose before conversion end");
   cmd_ignore_a: assert property (@(posedge clk) disable iff (rst) // see RL3
      (in_conv(state_reg) && !conv_done) |=> in_conv(state_reg))
      else $error("conversion left early");
   busy_track_a: assert property (@(posedge clk) disable iff (rst) // see RL2
      (state_reg == sarc_pkg::SARC_TRACK && !start_ok) |=> busy_n)
      else $error("busy fell without start");
   start_hold_a: assert property (@(posedge clk) disable iff (rst) // see RL1
      (state_reg == sarc_pkg::SARC_TRACK && start_ok) |=> hold)
      else $error("no hold after start");
   filter_a: assert property (@(posedge clk) disable iff (rst) // see RL1
      (state_reg == sarc_pkg::SARC_TRACK && low_cnt_reg < 3'(START_CYC - 1)) |=> busy_n)
      else $error("start before minimum low time");
   filter_clear_a: assert property (@(posedge clk) disable iff (rst) // see RL8
      !both_low |=> (low_cnt_reg == 3'h0))
      else $error("low-time filter not cleared");
   sample_hold_a: assert property (@(posedge clk) disable iff (rst) // see RL1
      $rose(hold) |-> (sar_code_reg == $past(sample_code)))
      else $error("sample not taken at hold");
   conv_rise_a: assert property (@(posedge clk) disable iff (rst) // see RL16
      conv_done |=> busy_n)
      else $error("busy low after conversion end");
   busy_cause_a: assert property (@(posedge clk) disable iff (rst) // see RL20
      $rose(busy_n) |-> $past(conv_done))
      else $error("busy rose without conversion end");
   conv_result_a: assert property (@(posedge clk) disable iff (rst) // see RL2
      conv_done |=> (result_reg == $past(sar_code_reg)))
      else $error("result register not updated");
   rearm_track_a: assert property (@(posedge clk) disable iff (rst) // see RL6
      (state_reg == sarc_pkg::SARC_REARM && !both_low) |=> (busy_n && !hold))
      else $error("no return to tracking");
   rearm_hold_a: assert property (@(posedge clk) disable iff (rst) // see RL5
      (state_reg == sarc_pkg::SARC_REARM && both_low) |=> hold)
      else $error("restart without hold");
   rearm_once_a: assert property (@(posedge clk) disable iff (rst) // see RL5
      (state_reg == sarc_pkg::SARC_REARM) |=> (state_reg != sarc_pkg::SARC_REARM))
      else $error("rearm state held");
   // ****************************************
   // checks: result bus
   // ****************************************
   // enables move together, data lanes follow the result register
   oe_drive_a: assert property (@(posedge clk) disable iff (rst) // see RL10
      read_en |=> (result_lines_oe_n == 16'h0000))
      else $error("bus not driven on read");
   oe_uniform_a: assert property (@(posedge clk) disable iff (rst) // see RL10
      (result_lines_oe_n == 16'h0000) || (result_lines_oe_n == 16'hffff))
      else $error("bus enables split");
   conv_float_a: assert property (@(posedge clk) disable iff (rst) // see RL12
      both_low |=> (result_lines_oe_n == 16'hffff))
      else $error("bus driven during convert command");
   msb_first_a: assert property (@(posedge clk) disable iff (rst) // see RL21
      !byte_sel |=> (result_lines_out[15:4] == $past(result_reg)))
      else $error("word lanes wrong");
   swap_pad_a: assert property (@(posedge clk) disable iff (rst) // see RL21
      byte_sel |=> (result_lines_out[11:8] == 4'h0))
      else $error("swapped padding not low");
   swap_data_a: assert property (@(posedge clk) disable iff (rst) // see RL15
      byte_sel |=> ({result_lines_out[7:0], result_lines_out[15:12]} == $past(result_reg)))
      else $error("swapped lanes wrong");
   // ****************************************
   // checks: timers and log
   // ****************************************
   // counters stay in range and restart with each conversion
   cnt_start_a: assert property (@(posedge clk) disable iff (rst) // see RL20
      $fell(busy_n) |-> (conv_cnt_reg == 14'h0000))
      else $error("conversion timer not restarted");
   cnt_idle_a: assert property (@(posedge clk) disable iff (rst) // see RL20
      !in_conv(state_reg) |=> (conv_cnt_reg == 14'h0000))
      else $error("conversion timer runs idle");
   cnt_bound_a: assert property (@(posedge clk) disable iff (rst) // see RL20
      conv_cnt_reg <= 14'(CONV_CYC - 1))
      else $error("conversion timer past end");
   age_zero_a: assert property (@(posedge clk) disable iff (rst) // see RL17
      !in_conv(state_reg) |=> (age_cnt_reg == 11'h000))
      else $error("age counter not cleared");
   old_valid_a: assert property (@(posedge clk) disable iff (rst) // see RL17
      (in_conv(state_reg) && age_cnt_reg < 11'(OLD_CYC) && !conv_done) |=> $stable(result_reg))
      else $error("old result lost too early");
   // a drop is only reported for a finished result that found no room
   fifo_push_a: assert property (@(posedge clk) disable iff (rst) // see RL22
      (conv_done && fifo_in_ready) |=> (log_valid && !sample_dropped))
      else $error("finished result not logged");
   drop_pulse_a: assert property (@(posedge clk) disable iff (rst) // see RL22
      sample_dropped |-> $past(conv_done))
      else $error("drop without finished result");
endmodule // sarc_core
`default_nettype wire

// ---- verilog/sarc_map.svh ----
`ifndef SARC_MAP_SVH
`define SARC_MAP_SVH
// ****************************************
// timing and layout constants
// ****************************************
`define SARC_CLK_PERIOD_NS   10
`define SARC_START_MIN_NS    40
`define SARC_START_CYC       ((`SARC_START_MIN_NS + `SARC_CLK_PERIOD_NS - 1) / `SARC_CLK_PERIOD_NS)
`define SARC_CONV_US         8
`define SARC_CONV_CYC        ((`SARC_CONV_US * 1000) / `SARC_CLK_PERIOD_NS)
`define SARC_OLD_VALID_US    16
`define SARC_OLD_VALID_CYC   ((`SARC_OLD_VALID_US * 1000) / `SARC_CLK_PERIOD_NS)
`define SARC_RES_W           12
`define SARC_BUS_W           16
`define SARC_HALF_W          8
`define SARC_RESULT_RESET    12'h000
`define SARC_FIFO_DEPTH      32
`endif

// ---- verilog/sarc_pkg.sv ----
package sarc_pkg;
   // ****************************************
   // conversion control states
   // ****************************************
   typedef enum logic [1:0] {
      SARC_TRACK   = 2'b00,
      SARC_CONVERT = 2'b01,
      SARC_REARM   = 2'b10
   } sarc_state_e;
   typedef logic [11:0] sarc_code_t;
endpackage

// ---- verilog/sarc_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// sample fifo
// ****************************************
module sarc_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0]      wr_reg;
   logic [AW:0]      rd_reg;
   logic             push;
   logic             pop;
   // full when pointers differ only in wrap bit
   assign in_ready  = !((wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
   assign out_valid = (wr_reg != rd_reg);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_reg[rd_reg[AW-1:0]];
   // storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_reg[AW-1:0]] <= in_data;
      end
   end
   // pointers
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= rd_reg + 1'b1;
         end
      end
   end
endmodule // sarc_fifo
`default_nettype wire

// ---- verilog/sarc_lanes.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sarc_map.svh"
// ****************************************
// result lane arrangement
// ****************************************
module sarc_lanes (
   input  wire logic [`SARC_RES_W-1:0] code,
   input  wire logic                   byte_swap,
   output logic      [`SARC_BUS_W-1:0] lanes
);
   logic [`SARC_BUS_W-1:0] word;
   // msb first, four padding zeros in the low group
   assign word  = {code, 4'h0}; // see RL21
   // swap upper and lower byte groups
   assign lanes = byte_swap ? {word[7:0], word[15:8]} : word; // see RL21 see RL15
endmodule // sarc_lanes
`default_nettype wire

// ---- test/sarc_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// host side of the convert and read lines
// ****************************************
module sarc_host_model (
   input  wire logic clk,
   input  wire logic busy_n,
   output logic      select_n,
   output logic      read_conv,
   output logic      byte_sel
);
   // idle: bus off, no command pending
   initial begin
      select_n  = 1'b1;
      read_conv = 1'b1;
      byte_sel  = 1'b0;
   end
   // the other line goes low a cycle ahead, so the chosen line starts it
   task automatic start(input logic rc_last, output logic ok);
      int n;
      n = 0;
      @(negedge clk);
      if (rc_last) select_n = 1'b0; else read_conv = 1'b0;
      @(negedge clk);
      if (rc_last) read_conv = 1'b0; else select_n = 1'b0;
      while (busy_n !== 1'b0 && n < 20) begin
         @(negedge clk);
         n++;
      end
      ok = (busy_n === 1'b0);
   endtask
   // both lines up at the next falling clock edge
   task automatic release_ctl();
      @(negedge clk);
      select_n  = 1'b1;
      read_conv = 1'b1;
   endtask
   // bounded wait for the end of a conversion
   task automatic finish(output logic ok);
      int n;
      n = 0;
      while (busy_n !== 1'b1 && n < 900) begin
         @(negedge clk);
         n++;
      end
      ok = (busy_n === 1'b1);
   endtask
   // idle gap so that the next sample is acquired properly
   task automatic space();
      repeat (200) @(negedge clk);
   endtask
   // bus enabled; waits two cycles so the registered answer has landed
   task automatic read(input logic bsel);
      @(negedge clk);
      select_n  = 1'b0;
      read_conv = 1'b1;
      byte_sel  = bsel;
      repeat (2) @(negedge clk);
   endtask
endmodule // sarc_host_model
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sarc_map.svh"
module testbench;
   logic        clk         = 1'b0;
   logic        rst         = 1'b1;
   logic        log_ready;
   logic [11:0] sample_code;
   logic        select_n, read_conv, byte_sel, busy_n, hold, log_valid, sample_dropped;
   logic [15:0] bus_out, bus_oe_n;
   logic [11:0] log_data;
   logic [11:0] exp_q[$];
   int          n_errors    = 0;
   int          n_checks    = 0;
   int          n_drops     = 0;
   int          low_cnt     = 0;
   int          last_low    = 0;
   always #5 clk = ~clk;
   sarc_host_model i_host (.clk(clk), .busy_n(busy_n), .select_n(select_n), .read_conv(read_conv),
                           .byte_sel(byte_sel));
   sarc_core i_dut (.clk(clk), .rst(rst), .select_n(select_n), .read_conv(read_conv), .byte_sel(byte_sel),
                    .sample_code(sample_code), .busy_n(busy_n), .hold(hold), .result_lines_out(bus_out),
                    .result_lines_oe_n(bus_oe_n), .log_data(log_data), .log_valid(log_valid),
                    .log_ready(log_ready), .sample_dropped(sample_dropped));
   // busy length latched when busy returns high; drop pulses counted
   always @(posedge clk) begin
      if (sample_dropped === 1'b1) n_drops++;
      if (busy_n === 1'b0) low_cnt++;
      else if (low_cnt != 0) begin
         last_low = low_cnt;
         low_cnt  = 0;
      end
   end
   task automatic chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // expected lanes: result on top, padding low, halves swapped on request
   function automatic logic [15:0] lanes(input logic [11:0] c, input logic b);
      logic [15:0] w;
      w = {c, 4'h0};
      return b ? {w[7:0], w[15:8]} : w;
   endfunction
   task automatic finish_test();
      if (n_errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic t_reset();
      chk1(busy_n, 1'b1);
      chk1(hold, 1'b0);
      chk16(bus_oe_n, 16'hffff);
      chk1(log_valid, 1'b0);
   endtask
   // select held low, read line starts it; a second command mid-conversion
   task automatic t_single();
      logic ok;
      i_host.read(1'b0);
      chk16(bus_oe_n, 16'h0000);
      chk16(bus_out, lanes(12'h000, 1'b0));
      sample_code = 12'h800;
      i_host.start(1'b1, ok);
      chk1(ok, 1'b1);
      chk1(hold, 1'b1);
      chk16(bus_oe_n, 16'hffff);
      sample_code = 12'h3c5;
      i_host.read(1'b0);
      chk16(bus_out, lanes(12'h000, 1'b0));
      i_host.start(1'b1, ok);
      i_host.read(1'b0);
      i_host.finish(ok);
      chk1(ok, 1'b1);
      @(negedge clk);
      chk16(bus_out, lanes(12'h800, 1'b0));
      i_host.read(1'b1);
      chk16(bus_out, lanes(12'h800, 1'b1));
      chk16(last_low[15:0], 16'(`SARC_CONV_CYC));
      chk1(hold, 1'b0);
      exp_q.push_back(12'h800);
      i_host.release_ctl();
      i_host.space();
   endtask
   // select falls last; codes at both ends and just below midscale
   task automatic t_codes();
      logic [11:0] codes[3] = '{12'h000, 12'h7ff, 12'hfff};
      logic        ok;
      foreach (codes[i]) begin
         sample_code = codes[i];
         i_host.start(1'b0, ok);
         chk1(ok, 1'b1);
         chk16(bus_oe_n, 16'hffff);
         sample_code = ~codes[i];
         i_host.release_ctl();
         i_host.finish(ok);
         i_host.read(1'b0);
         chk16(bus_out, lanes(codes[i], 1'b0));
         exp_q.push_back(codes[i]);
         i_host.release_ctl();
         i_host.space();
      end
   endtask
   // lines left low across the end of busy on purpose
   task automatic t_restart();
      logic ok;
      sample_code = 12'h5a5;
      i_host.start(1'b1, ok);
      i_host.finish(ok);
      chk1(ok, 1'b1);
      repeat (3) @(negedge clk);
      chk1(busy_n, 1'b0);
      exp_q.push_back(12'h5a5);
      exp_q.push_back(12'h5a5);
      i_host.release_ctl();
      i_host.finish(ok);
      i_host.space();
   endtask
   // fill the log until a result is dropped, then drain with stalls
   task automatic t_fifo();
      int   n;
      logic ok;
      n = 32 - exp_q.size();
      for (int i = 0; i <= n; i++) begin
         sample_code = 12'h100 + 12'(i);
         i_host.start(1'b1, ok);
         i_host.release_ctl();
         i_host.finish(ok);
         if (i < n) exp_q.push_back(12'h100 + 12'(i));
         i_host.space();
      end
      chk16(16'(n_drops), 16'h0001);
      for (int k = 0; k < 200 && exp_q.size() > 0; k++) begin
         @(negedge clk);
         log_ready = k[0];
         if (log_ready && log_valid === 1'b1) chk16({log_data, 4'h0}, {exp_q.pop_front(), 4'h0});
      end
      @(negedge clk);
      chk1(log_valid, 1'b0);
   endtask
   // watchdog: the tests need about 33000 cycles
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      finish_test();
   end
   initial begin
      log_ready   = 1'b0;
      sample_code = 12'h000;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_single();
      t_codes();
      t_restart();
      t_fifo();
      finish_test();
   end
endmodule // testbench
`default_nettype wire
